// *** src/pbc_pkg.sv ***
// Package for the four-channel PWM counter and brake block.
// Assumes word-aligned AHB-Lite access; register byte address is four times its index.
package pbc_pkg;
  // ==========================================================================
  // Register indices (byte address = index * 4).
  // ==========================================================================
  localparam logic [7:0] IDX_PERIOD_LO = 8'hd9;  // Period low bits.
  localparam logic [7:0] IDX_DUTY0_LO  = 8'hda;  // Channel 0 duty low bits.
  localparam logic [7:0] IDX_DUTY1_LO  = 8'hdb;  // Channel 1 duty low bits.
  localparam logic [7:0] IDX_CTL1      = 8'hdc;  // Run, reload, flag, clear, invert.
  localparam logic [7:0] IDX_DUTY2_LO  = 8'hdd;  // Channel 2 duty low bits.
  localparam logic [7:0] IDX_DUTY3_LO  = 8'hde;  // Channel 3 duty low bits.
  localparam logic [7:0] IDX_BRAKE     = 8'hdf;  // Brake control.
  localparam logic [7:0] IDX_IRQ_EN    = 8'he8;  // Extended interrupt enable.
  localparam logic [7:0] IDX_HIGH_BITS = 8'hd0;  // Upper two bits of period and duties.
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hd1;  // Sticky event status, read only.
  localparam logic [7:0] IDX_IRQ_CLR   = 8'hd2;  // Write one to clear status, write only.
  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int BIT_RUN     = 7;  // Counter run bit.
  localparam int BIT_RELOAD  = 6;  // Reload request bit.
  localparam int BIT_UFLOW   = 5;  // Underflow flag.
  localparam int BIT_CLEAR   = 4;  // Counter clear bit.
  localparam int BIT_QUALIFY = 7;  // Brake run-qualify.
  localparam int BIT_POL     = 6;  // Brake pin polarity.
  localparam int BIT_PINSEL  = 5;  // Brake pin select.
  localparam int BIT_BRAKE_ENABLE    = 4;  // Brake enable.
  localparam int BIT_BRK_EV  = 5;  // External brake event in enable and status.
  // ==========================================================================
  // Reset values and widths.
  // ==========================================================================
  localparam int          CNT_W     = 10;     // Down-counter width.
  localparam int          NUM_CH    = 4;      // Output channels.
  localparam logic [7:0]  RST_BYTE  = 8'h00;  // Reset value of every register.
  localparam logic [9:0]  CNT_MAX   = 10'h3ff; // Wrap value without reload.
  localparam int          TICK_DIV  = 1;      // Clock cycles per counter step.
endpackage : pbc_pkg

// *** src/pbc_pwm_brake.sv ***
// Four-channel PWM generator with 10-bit down-counter and brake unit, AHB-Lite slave.
// Assumes a single 125 MHz clock hclk and asynchronous active-low reset hresetn;
// the brake pin arrives asynchronously and is synchronised here.
//
// How it works
// - Run bit starts and stops the counter.
// - Reload copies period after underflow, self-clears.
// - Underflow sets flag until software clears.
// - Writing clear bit zeroes the counter.
// - Per-channel invert bits invert each output.
// - Polarity bit selects brake pin active level.
// - Brake never asserts while brake enable low.
// - Braked outputs take their brake-level bits.
// - Software brake leaves run bit, generator running.
// - Software brake release shows live generator output.
// - Run-qualify brake acts only while stopped.
// - Stopped brake release restores stopped output.
// - Pin brake forces levels, clears run, flags.
// - Pin brake releases on pin idle and disable.
// - Brake interrupt enable gates pin-brake interrupt.
// - Channels 2 and 3 duty low registers.
// - Period low register feeds counter reload.
// - Channels 0 and 1 duty low registers.
`timescale 1ns/1ps
module pbc_pwm_brake
  import pbc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_DIV  // Clock cycles per counter step.
) (
  // Clock and reset.
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave.
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Brake pin and outputs.
  input  wire logic                 brake_input_pin,
  output logic      [NUM_CH-1:0]    pwm_out,
  output logic                      irq
);
  // ==========================================================================
  // Elaboration check.
  // ==========================================================================
  // The step divider holds at most 256 cycles.
  if (TICK_CYCLES < 1 || TICK_CYCLES > 256) begin : g_bad_div
    $error("TICK_CYCLES must lie between 1 and 256");
  end

  // ==========================================================================
  // Registers.
  // ==========================================================================
  logic              run_r;                   // Counter run bit.
  logic              reload_r;                // Reload request bit.
  logic              uflow_r;                 // Underflow flag.
  logic [NUM_CH-1:0] invert_r;                // Output invert bits.
  logic [7:0]        brake_r;                 // Brake control register.
  logic              brk_irq_en_r;            // Brake interrupt enable.
  logic              brk_stat_r;              // Sticky external brake flag.
  logic [7:0]        period_lo_r;             // Period low bits.
  logic [7:0]        duty_lo_r [NUM_CH];      // Duty low bits per channel.
  logic [9:0]        high_bits_r;             // {duty3..0 hi, period hi}.
  logic [CNT_W-1:0]  cnt_r;                   // Down-counter.
  logic [CNT_W-1:0]  duty_act_r [NUM_CH];     // Active compare values.
  logic              ext_brk_r;               // Latched pin brake.
  logic [7:0]        div_r;                   // Step divider.
  logic              tick_r;                  // One-cycle step enable.
  logic [2:0]        pin_sync_r;              // Pin synchroniser chain.
  logic              pin_lvl_r;               // Settled pin level.

  // ==========================================================================
  // AHB-Lite slave: address phase capture and data phase writes.
  // ==========================================================================
  logic       wr_pend_r;  // Write data phase pending.
  logic [7:0] wr_idx_r;   // Index of pending write.
  logic       rd_take;    // Read accepted this cycle.
  logic       wr_take;    // Write accepted this cycle.
  logic [7:0] addr_idx;   // Index of current address phase.
  logic       wr_now;     // Write data valid this cycle.
  logic [7:0] wdat;       // Written byte.

  assign addr_idx = haddr[9:2];
  assign rd_take  = hsel && hready && htrans[1] && !hwrite;
  assign wr_take  = hsel && hready && htrans[1] && hwrite;
  assign wr_now   = wr_pend_r;
  assign wdat     = hwdata[7:0];

  // Capture the write address; data follows one cycle later.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end else begin
      wr_pend_r <= wr_take;
      wr_idx_r  <= addr_idx;
    end
  end

  // Zero wait states and always OKAY; a read right after a write to the same
  // register would see old data, which the single-transfer master never does.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data is registered in the address phase so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      unique case (addr_idx)
        IDX_PERIOD_LO: hrdata <= {24'h000000, period_lo_r};
        IDX_DUTY0_LO:  hrdata <= {24'h000000, duty_lo_r[0]};
        IDX_DUTY1_LO:  hrdata <= {24'h000000, duty_lo_r[1]};
        IDX_DUTY2_LO:  hrdata <= {24'h000000, duty_lo_r[2]};
        IDX_DUTY3_LO:  hrdata <= {24'h000000, duty_lo_r[3]};
        IDX_CTL1:      hrdata <= {24'h000000, run_r, reload_r, uflow_r, 1'b0, invert_r};
        IDX_BRAKE:     hrdata <= {24'h000000, brake_r};
        IDX_IRQ_EN:    hrdata <= {26'h0000000, brk_irq_en_r, 5'h00};
        IDX_HIGH_BITS: hrdata <= {22'h000000, high_bits_r};
        IDX_IRQ_STAT:  hrdata <= {26'h0000000, brk_stat_r, 5'h00};
        default:       hrdata <= 32'h0000_0000;  // Unmapped and write-only read zero.
      endcase
    end
  end

  // Decoded control writes.
  logic wr_ctl1;    // Control register 1 written.
  logic clr_pulse;  // Counter clear strobe.
  assign wr_ctl1   = wr_now && (wr_idx_r == IDX_CTL1);
  assign clr_pulse = wr_ctl1 && wdat[BIT_CLEAR];

  // Plain data registers: period, duties, high bits, brake control, enable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_lo_r  <= RST_BYTE;
      for (int i = 0; i < NUM_CH; i++) duty_lo_r[i] <= RST_BYTE;
      high_bits_r  <= 10'h000;
      brake_r      <= RST_BYTE;
      brk_irq_en_r <= 1'b0;
      invert_r     <= 4'h0;
    end else if (wr_now) begin
      unique case (wr_idx_r)
        IDX_PERIOD_LO: period_lo_r  <= wdat;
        IDX_DUTY0_LO:  duty_lo_r[0] <= wdat;
        IDX_DUTY1_LO:  duty_lo_r[1] <= wdat;
        IDX_DUTY2_LO:  duty_lo_r[2] <= wdat;
        IDX_DUTY3_LO:  duty_lo_r[3] <= wdat;
        IDX_HIGH_BITS: high_bits_r  <= hwdata[9:0];
        IDX_BRAKE:     brake_r      <= wdat;
        IDX_IRQ_EN:    brk_irq_en_r <= wdat[BIT_BRK_EV];
        IDX_CTL1:      invert_r     <= wdat[NUM_CH-1:0];
        default:       ;
      endcase
    end
  end

  // ==========================================================================
  // Brake pin synchroniser: three flops, change accepted when last two agree.
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync_r <= 3'b000;
      pin_lvl_r  <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], brake_input_pin};
      if (pin_sync_r[1] == pin_sync_r[2]) pin_lvl_r <= pin_sync_r[2];
    end
  end

  // ==========================================================================
  // Brake condition decode.
  // ==========================================================================
  logic brake_enable;       // Brake enable.
  logic pinsel;     // Pin select.
  logic qualify;    // Run-qualify.
  logic pin_act;    // Pin at its asserted level.
  logic ext_trig;   // Pin brake trigger.
  logic brake_act;  // Outputs forced to brake levels.
  assign brake_enable     = brake_r[BIT_BRAKE_ENABLE];
  assign pinsel   = brake_r[BIT_PINSEL];
  assign qualify  = brake_r[BIT_QUALIFY];
  assign pin_act  = (pin_lvl_r == brake_r[BIT_POL]);
  assign ext_trig = brake_enable && pinsel && !qualify && pin_act;

  // The mode table: software, stopped-counter, pin, or none.
  always_comb begin
    brake_act = 1'b0;
    if (brake_enable) begin
      unique case ({pinsel, qualify})
        2'b00:   brake_act = 1'b1;
        2'b01:   brake_act = !run_r;
        2'b10:   brake_act = ext_brk_r || pin_act;
        default: brake_act = 1'b0;
      endcase
    end
  end

  // Pin brake latches until the pin is idle and software drops brake enable;
  // a fresh trigger wins over the release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_brk_r <= 1'b0;
    end else if (ext_trig) begin
      ext_brk_r <= 1'b1;
    end else if (!brake_enable && !pin_act) begin
      ext_brk_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt status, enable and output.
  // ==========================================================================
  // Sticky external brake flag; an event wins over a simultaneous clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_stat_r <= 1'b0;
    end else if (ext_trig) begin
      brk_stat_r <= 1'b1;
    end else if (wr_now && wr_idx_r == IDX_IRQ_CLR && wdat[BIT_BRK_EV]) begin
      brk_stat_r <= 1'b0;
    end
  end

  // Level interrupt while the enabled flag is set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    else          irq <= brk_stat_r && brk_irq_en_r;
  end

  // ==========================================================================
  // Counter step divider.
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end else if (div_r == 8'(TICK_CYCLES - 1)) begin
      div_r  <= 8'h00;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Run, reload and underflow flags.
  // ==========================================================================
  logic uf_event;  // Counter steps below zero.
  assign uf_event = run_r && tick_r && (cnt_r == '0) && !clr_pulse;

  // Hardware stop from the pin brake wins over a software start.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'b0;
    end else if (ext_trig) begin
      run_r <= 1'b0;
    end else if (wr_ctl1) begin
      run_r <= wdat[BIT_RUN];
    end
  end

  // Reload request clears once the transfer has happened.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_r <= 1'b0;
    end else if (uf_event && reload_r) begin
      reload_r <= 1'b0;
    end else if (wr_ctl1) begin
      reload_r <= wdat[BIT_RELOAD];
    end
  end

  // Underflow flag: software may only clear it, and a new underflow wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uflow_r <= 1'b0;
    end else if (uf_event) begin
      uflow_r <= 1'b1;
    end else if (wr_ctl1 && !wdat[BIT_UFLOW]) begin
      uflow_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Down-counter and compare value transfer.
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else if (clr_pulse) begin
      cnt_r <= '0;
    end else if (uf_event) begin
      cnt_r <= reload_r ? {high_bits_r[1:0], period_lo_r} : CNT_MAX;
    end else if (run_r && tick_r) begin
      cnt_r <= cnt_r - 10'd1;
    end
  end

  // Duty values move into the comparators only with a reload transfer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_CH; i++) duty_act_r[i] <= '0;
    end else if (uf_event && reload_r) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_act_r[i] <= {high_bits_r[2*i+3 -: 2], duty_lo_r[i]};
      end
    end
  end

  // ==========================================================================
  // Output stage: compare, invert, brake override.
  // ==========================================================================
  logic [NUM_CH-1:0] gen;  // Live generator output after inversion.
  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    assign gen[n] = (cnt_r < duty_act_r[n]) ^ invert_r[n];
  end

  // A stopped counter freezes gen, so releasing any brake shows the state the
  // generator held before it; a running one shows its live value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pwm_out <= '0;
    else          pwm_out <= brake_act ? brake_r[NUM_CH-1:0] : gen;
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_pin_trig; ext_trig && !wr_now; endsequence
  sequence s_stopped_flagged; !run_r && brk_stat_r && ext_brk_r; endsequence

  property p_stop_hold;
    !run_r && !clr_pulse |=> cnt_r == $past(cnt_r);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped");

  property p_reload;
    uf_event && reload_r |=> !reload_r && cnt_r == {$past(high_bits_r[1:0]), $past(period_lo_r)};
  endproperty
  a_reload: assert property (p_reload) else $error("reload not performed");

  property p_uflow;
    uf_event |=> uflow_r [*2] or (uflow_r ##1 $past(wr_ctl1));
  endproperty
  a_uflow: assert property (p_uflow) else $error("underflow flag not held");

  property p_clear;
    clr_pulse |=> cnt_r == 10'h000;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared");

  property p_no_brake;
    !brake_enable |=> pwm_out == $past(gen);
  endproperty
  a_no_brake: assert property (p_no_brake) else $error("output not generator");

  property p_brake_level;
    brake_act |=> pwm_out == $past(brake_r[NUM_CH-1:0]);
  endproperty
  a_brake_level: assert property (p_brake_level) else $error("brake level wrong");

  property p_sw_brake;
    brake_enable && !pinsel && !qualify && !wr_now |=> brake_act && run_r == $past(run_r);
  endproperty
  a_sw_brake: assert property (p_sw_brake) else $error("software brake wrong");

  property p_qualify;
    brake_enable && !pinsel && qualify |=> pwm_out == $past(run_r ? gen : brake_r[NUM_CH-1:0]);
  endproperty
  a_qualify: assert property (p_qualify) else $error("stopped brake wrong");

  property p_pin_brake;
    s_pin_trig |=> s_stopped_flagged ##1 pwm_out == $past(brake_r[NUM_CH-1:0], 2);
  endproperty
  a_pin_brake: assert property (p_pin_brake) else $error("pin brake wrong");

  property p_irq;
    brk_stat_r && brk_irq_en_r |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule // pbc_pwm_brake

// *** bench/pbc_stage_model.sv ***
// Power stage model that sits on the PWM outputs and owns the brake pin.
// Assumes the bench asks for a fault with trip and sets the pin's active level.
`timescale 1ns/1ps
module pbc_stage_model (
  // Clock and stage inputs.
  input  wire logic       hclk,
  input  wire logic [3:0] pwm_out,
  // Fault request from the bench.
  input  wire logic       trip,
  input  wire logic       act_lvl,
  // Brake pin towards the block.
  output logic            brake_pin = 1'b1
);
  // ==========================================================================
  // Fault line
  // ==========================================================================
  // The pin is a level; the stage holds it for as long as the fault lasts.
  // Releasing it alone does not free the outputs; software must also act.
  always @(posedge hclk) begin
    brake_pin <= trip ? act_lvl : ~act_lvl;
  end
endmodule // pbc_stage_model

// *** bench/pbc_pwm_brake_bench.sv ***
// Self-checking bench for the PWM counter and brake block.
// Assumes one AHB-Lite slave with hready fed back from hreadyout.
`timescale 1ns/1ps
module pbc_pwm_brake_bench;
  import pbc_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize  = 3'h2;
  logic        hreadyout, hresp, irq, pin, trip = 1'b0, act = 1'b0;
  logic [3:0]  pwm_out, lvl, inv, dty, raw;
  logic [9:0]  hb;  // Random upper bits of period and duties.
  int          n_fail = 0, checks = 0;
  int          mreg[int];  // Shadow of written register bytes.
  logic [7:0]  dl[5] = '{IDX_PERIOD_LO, IDX_DUTY0_LO, IDX_DUTY1_LO, IDX_DUTY2_LO,
                         IDX_DUTY3_LO};
  logic [7:0]  ri[5] = '{IDX_CTL1, IDX_BRAKE, IDX_IRQ_EN, IDX_IRQ_STAT, 8'h00};
  // ==========================================================================
  // Design and partner
  // ==========================================================================
  pbc_pwm_brake #(.TICK_CYCLES(1)) i_pbc_pwm_brake (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .brake_input_pin(pin), .pwm_out(pwm_out), .irq(irq));
  pbc_stage_model i_pbc_stage_model (
    .hclk(hclk), .pwm_out(pwm_out), .trip(trip), .act_lvl(act), .brake_pin(pin));
  // 125 MHz clock.
  initial begin
    forever #4 hclk = ~hclk;
  end
  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Compare and count; a mismatch is reported at once.
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single transfer; waits on hready, so no latency is assumed.
  task automatic bus(logic wr_en, logic [7:0] idx, logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= wr_en;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(logic [7:0] idx, logic [31:0] d);
    bus(1'b1, idx, d);
    mreg[idx] = d[7:0];
  endtask
  task automatic rdc(logic [7:0] idx, logic [31:0] mask, logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check($sformatf("reg %h", idx), rd & mask, exp);
    check("hresp", 32'(hresp), 32'h0);
  endtask
  // Let a few edges pass, then compare the outputs.
  task automatic pwm_is(logic [3:0] exp);
    repeat (10) @(posedge hclk);
    check("pwm_out", 32'(pwm_out), 32'(exp));
  endtask
  // Single place where the run ends.
  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog: the tests need well under 2000 cycles.
  initial begin
    #200000;
    n_fail++;
    end_sim;
  end
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    void'($urandom(32'h209fb2dd));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 5; i++) rdc(ri[i], 32'hffffffff, 32'h0);
    // Period kept large so no underflow lands between flag checks.
    for (int i = 0; i < 5; i++) wr(dl[i], $urandom_range(255, i == 0 ? 64 : 0));
    for (int i = 0; i < 5; i++) rdc(dl[i], 32'hffffffff, mreg[dl[i]]);
    // Zero duties keep the raw compare low, so outputs equal the invert bits.
    for (int i = 1; i < 5; i++) wr(dl[i], 32'h0);
    inv = 4'($urandom_range(15));
    lvl = ~inv;
    wr(IDX_CTL1, 32'h10 | inv);
    rdc(IDX_CTL1, 32'hff, 32'(inv));
    wr(IDX_CTL1, 32'hc0 | inv);
    repeat (4) @(posedge hclk);
    rdc(IDX_CTL1, 32'hff, 32'ha0 | inv);
    wr(IDX_CTL1, 32'h80 | inv);
    rdc(IDX_CTL1, 32'hff, 32'h80 | inv);
    wr(IDX_CTL1, 32'h90 | inv);
    repeat (3) @(posedge hclk);
    rdc(IDX_CTL1, 32'hff, 32'ha0 | inv);
    pwm_is(inv);
    // Software brake while running.
    wr(IDX_BRAKE, 32'h10 | lvl);
    pwm_is(lvl);
    rdc(IDX_CTL1, 32'h80, 32'h80);
    wr(IDX_BRAKE, 32'(lvl));
    pwm_is(inv);
    // Brake qualified by the stopped counter.
    wr(IDX_BRAKE, 32'h90 | lvl);
    pwm_is(inv);
    wr(IDX_CTL1, 32'(inv));
    pwm_is(lvl);
    wr(IDX_BRAKE, 32'(lvl));
    pwm_is(inv);
    // Pin brake at both polarities, interrupt allowed only on the second pass.
    for (int p = 0; p < 2; p++) begin
      act <= p[0];
      wr(IDX_IRQ_EN, 32'(p << 5));
      wr(IDX_CTL1, 32'h80 | inv);
      wr(IDX_BRAKE, 32'h30 | (p << 6) | lvl);
      pwm_is(inv);
      trip <= 1'b1;
      pwm_is(lvl);
      check("irq", 32'(irq), 32'(p));
      rdc(IDX_IRQ_STAT, 32'h20, 32'h20);
      rdc(IDX_CTL1, 32'h80, 32'h0);
      trip <= 1'b0;
      pwm_is(lvl);
      wr(IDX_BRAKE, 32'(lvl));
      pwm_is(inv);
      wr(IDX_IRQ_CLR, 32'h20);
      rdc(IDX_IRQ_STAT, 32'h20, 32'h0);
      check("irq", 32'(irq), 32'h0);
    end
    // Stopped and cleared, the counter sits at zero, so after a reload each
    // raw output is high exactly when its full 10-bit duty is non-zero.
    hb  = 10'($urandom_range(1023));
    dty = 4'($urandom_range(15));
    wr(IDX_HIGH_BITS, 32'(hb));
    rdc(IDX_HIGH_BITS, 32'h3ff, 32'(hb));
    for (int i = 1; i < 5; i++) wr(dl[i], 32'(dty[i-1]));
    for (int n = 0; n < 4; n++) raw[n] = dty[n] || (hb[2*n+2 +: 2] != 2'b00);
    wr(IDX_CTL1, 32'hd0 | inv);
    wr(IDX_CTL1, 32'h10 | inv);
    pwm_is(raw ^ inv);
    end_sim;
  end
endmodule // pbc_pwm_brake_bench
